/* logic/dac_cmd_pkg.sv */
// Package of constants for the octal DAC serial command logic.
// Assumes a 200 MHz system clock; link clock is the serial clock from the host.
package dac_cmd_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int SHIFT_BITS = 32;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_LSB = 0;
    localparam int CODE_BITS = 16;
    localparam int CHANNELS = 8;
    // ------------------------------------------------------------
    // Command and address codes
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_WRITE = 4'h0;
    localparam logic [3:0] CMD_UPDATE = 4'h1;
    localparam logic [3:0] CMD_WRITE_UPDATE_ALL = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
    localparam logic [3:0] CMD_NOP = 4'hF;
    localparam logic [3:0] ADDR_ALL = 4'hF;
    localparam logic [3:0] ADDR_LAST = 4'h7;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [7:0] POWER_DOWN_RESET = 8'h00;
    // ------------------------------------------------------------
    // Power-up delays
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 200;
    localparam int PWRUP_PARTIAL_US = 5;
    localparam int PWRUP_FULL_5V_US = 12;
    localparam int PWRUP_FULL_3V_US = 30;
    localparam int PWRUP_PARTIAL_CYC = PWRUP_PARTIAL_US * CLOCK_MHZ;
    localparam int PWRUP_FULL_5V_CYC = PWRUP_FULL_5V_US * CLOCK_MHZ;
    localparam int PWRUP_FULL_3V_CYC = PWRUP_FULL_3V_US * CLOCK_MHZ;
    localparam int DELAY_BITS = 16;
endpackage : dac_cmd_pkg

/* logic/dac_link_shifter.sv */
// Serial-clock domain: 32-bit shift register and chain output.
// Assumes select_load_n low frames a transfer; shifts on serial clock rising edges.
`timescale 1ns/1ps
module dac_link_shifter
    import dac_cmd_pkg::*;
(
    input wire logic serial_clk_i,
    input wire logic rst_n_i,
    input wire logic select_load_n_i,
    input wire logic serial_in_i,
    output logic [SHIFT_BITS-1:0] shift_o,
    output logic chain_out_o
);
    logic [SHIFT_BITS-1:0] shift_reg;
    logic [SHIFT_BITS-1:0] shift_next;
    logic chain_reg;

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    always_comb begin
        shift_next = shift_reg;
        if (!select_load_n_i) begin
            shift_next = {shift_reg[SHIFT_BITS-2:0], serial_in_i};
        end
    end

    always_ff @(posedge serial_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // ------------------------------------------------------------
    // Chain output
    // ------------------------------------------------------------
    // oldest bit, falling edge
    always_ff @(negedge serial_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chain_reg <= 1'b0;
        end else begin
            chain_reg <= shift_reg[SHIFT_BITS-1];
        end
    end

    assign chain_out_o = chain_reg;
    assign shift_o = shift_reg;
endmodule : dac_link_shifter

/* logic/dac_delay_timer.sv */
// Down-counter that holds busy for a loaded number of cycles.
// Assumes load is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module dac_delay_timer
    import dac_cmd_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [DELAY_BITS-1:0] count_i,
    output logic busy_o
);
    logic [DELAY_BITS-1:0] count_reg;
    logic [DELAY_BITS-1:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (load_i) begin
            count_next = count_i;
        end else if (count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign busy_o = (count_reg != '0);
endmodule : dac_delay_timer

/* logic/dac_serial_command.sv */
// Top of the octal DAC serial command logic: link shifter, frame end
// crossing, command decode, input and DAC registers, power-down control.
// Assumes the serial clock idles between frames; the word is stable while
// select_load_n is high, so it is taken across after the line rises.
`timescale 1ns/1ps
//
// Operation
// - Shift only while select line low
// - Sample serial input on rising clock
// - Select rising edge executes received command
// - Accept 24 or 32 bit frames
// - Command, address, data, MSB first
// - Code MSB first, low padding ignored
// - Leading eight bits of 32 ignored
// - Decode write, update, power-down, no-op
// - Addresses 0-7 channels, 15 all
// - Write loads input register only
// - Update copies input to DAC register
// - Update powers channel back up
// - Power-down ignores data field
// - Power-down keeps register contents
// - Bias off when all eight down
// - Power-up delay 5, 12 or 30 us
// - Chain out delays 32 edges, falling
// - Chain out always driven
// - Clear low zeroes input and DAC registers
// - Power-on reset to zero scale
module dac_serial_command
    import dac_cmd_pkg::*;
#(
    parameter int RESOLUTION = 16,
    parameter int PWRUP_PARTIAL = PWRUP_PARTIAL_CYC,
    parameter int PWRUP_FULL_5V = PWRUP_FULL_5V_CYC,
    parameter int PWRUP_FULL_3V = PWRUP_FULL_3V_CYC
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic serial_clk_i,
    input wire logic select_load_n_i,
    input wire logic serial_in_i,
    input wire logic async_clear_n_i,
    input wire logic supply_3v_i,
    output logic chain_out_o,
    output logic [CHANNELS*CODE_BITS-1:0] channel_output_o,
    output logic [CHANNELS*CODE_BITS-1:0] input_code_o,
    output logic [CHANNELS-1:0] power_down_o,
    output logic bias_enable_o,
    output logic settling_hold_o,
    output logic command_done_o
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (RESOLUTION != 16 && RESOLUTION != 14 && RESOLUTION != 12) begin : g_bad_resolution
        $error("resolution must be 12, 14 or 16");
    end
    if (PWRUP_PARTIAL < 1 || PWRUP_FULL_5V < 1 || PWRUP_FULL_3V < 1 ||
        PWRUP_PARTIAL >= (1 << DELAY_BITS) || PWRUP_FULL_5V >= (1 << DELAY_BITS) ||
        PWRUP_FULL_3V >= (1 << DELAY_BITS)) begin : g_bad_delay
        $error("power-up delay counts out of range");
    end

    localparam int PAD_BITS = CODE_BITS - RESOLUTION;
    localparam logic [CODE_BITS-1:0] CODE_MASK = 16'hFFFF << PAD_BITS;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FRAME = 2'b01,
        ST_EXEC = 2'b10
    } exec_state_t;

    // ------------------------------------------------------------
    // Reset combination
    // ------------------------------------------------------------
    // clear acts asynchronously
    logic clr_rst_n;
    logic clr_meta_reg;
    logic clr_sync_reg;
    assign clr_rst_n = rst_n_i & async_clear_n_i;

    // Clear takes hold at once but lets go on the clock, so no register sees a late release
    always_ff @(posedge clock_i or negedge clr_rst_n) begin
        if (!clr_rst_n) begin
            clr_meta_reg <= 1'b0;
            clr_sync_reg <= 1'b0;
        end else begin
            clr_meta_reg <= 1'b1;
            clr_sync_reg <= clr_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------
    logic [SHIFT_BITS-1:0] link_word;

    dac_link_shifter u_shifter (
        .serial_clk_i(serial_clk_i),
        .rst_n_i(rst_n_i),
        .select_load_n_i(select_load_n_i),
        .serial_in_i(serial_in_i),
        .shift_o(link_word),
        .chain_out_o(chain_out_o)
    );

    // ------------------------------------------------------------
    // Select line synchroniser
    // ------------------------------------------------------------
    logic sel_meta_reg;
    logic sel_sync_reg;
    logic sel_prev_reg;
    logic supply_meta_reg;
    logic supply_3v_reg;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_meta_reg <= 1'b1;
            sel_sync_reg <= 1'b1;
            sel_prev_reg <= 1'b1;
            supply_meta_reg <= 1'b0;
            supply_3v_reg <= 1'b0;
        end else begin
            sel_meta_reg <= select_load_n_i;
            sel_sync_reg <= sel_meta_reg;
            sel_prev_reg <= sel_sync_reg;
            supply_meta_reg <= supply_3v_i;
            supply_3v_reg <= supply_meta_reg;
        end
    end

    logic sel_rise;
    logic sel_fall;
    assign sel_rise = sel_sync_reg & ~sel_prev_reg;
    assign sel_fall = ~sel_sync_reg & sel_prev_reg;

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    exec_state_t state_reg;
    exec_state_t state_next;
    logic [SHIFT_BITS-1:0] word_reg;
    logic [SHIFT_BITS-1:0] word_next;

    always_comb begin
        state_next = state_reg;
        word_next = word_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (sel_fall) begin
                    state_next = ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (sel_rise) begin
                    // Word is static: shifter holds its value while select_load_n is high
                    word_next = link_word;
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_next = sel_sync_reg ? ST_IDLE : ST_FRAME;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            word_reg <= '0;
        end else begin
            state_reg <= state_next;
            word_reg <= word_next;
        end
    end

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    // last 24 bits decoded
    logic [3:0] command_field;
    logic [3:0] channel_address;
    logic [CODE_BITS-1:0] data_code;
    assign command_field = word_reg[CMD_MSB:CMD_LSB];
    assign channel_address = word_reg[ADDR_MSB:ADDR_LSB];
    assign data_code = word_reg[DATA_MSB:DATA_LSB] & CODE_MASK;

    function automatic logic [CHANNELS-1:0] decode_addr(input logic [3:0] addr);
        logic [CHANNELS-1:0] sel;
        sel = '0;
        if (addr == ADDR_ALL) begin
            sel = '1;
        end else if (addr <= ADDR_LAST) begin
            sel[addr[2:0]] = 1'b1;
        end
        return sel;
    endfunction : decode_addr

    logic execute;
    logic [CHANNELS-1:0] chan_sel;
    logic [CHANNELS-1:0] write_sel;
    logic [CHANNELS-1:0] update_sel;
    logic [CHANNELS-1:0] down_sel;

    assign execute = (state_reg == ST_EXEC);
    assign chan_sel = decode_addr(channel_address);

    always_comb begin
        write_sel = '0;
        update_sel = '0;
        down_sel = '0;
        if (execute) begin
            unique case (command_field)
                CMD_WRITE: begin
                    write_sel = chan_sel;
                end
                CMD_UPDATE: begin
                    update_sel = chan_sel;
                end
                CMD_WRITE_UPDATE_ALL: begin
                    write_sel = chan_sel;
                    update_sel = '1;
                end
                CMD_WRITE_UPDATE: begin
                    write_sel = chan_sel;
                    update_sel = chan_sel;
                end
                CMD_POWER_DOWN: begin
                    down_sel = chan_sel;
                end
                default: begin
                    // No-op and reserved codes leave everything alone
                    write_sel = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Channel registers
    // ------------------------------------------------------------
    logic [CODE_BITS-1:0] input_reg [CHANNELS];
    logic [CODE_BITS-1:0] input_next [CHANNELS];
    logic [CODE_BITS-1:0] dac_reg [CHANNELS];
    logic [CODE_BITS-1:0] dac_next [CHANNELS];

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            always_comb begin
                input_next[ch] = input_reg[ch];
                dac_next[ch] = dac_reg[ch];
                if (write_sel[ch]) begin
                    input_next[ch] = data_code;
                end
                if (update_sel[ch]) begin
                    dac_next[ch] = write_sel[ch] ? data_code : input_reg[ch];
                end
            end

            always_ff @(posedge clock_i or negedge clr_sync_reg) begin
                if (!clr_sync_reg) begin
                    input_reg[ch] <= CODE_RESET;
                    dac_reg[ch] <= CODE_RESET;
                end else begin
                    input_reg[ch] <= input_next[ch];
                    dac_reg[ch] <= dac_next[ch];
                end
            end

            assign channel_output_o[ch*CODE_BITS +: CODE_BITS] = dac_reg[ch];
            assign input_code_o[ch*CODE_BITS +: CODE_BITS] = input_reg[ch];
        end
    endgenerate

    // ------------------------------------------------------------
    // Power-down state
    // ------------------------------------------------------------
    // power state apart from codes
    logic [CHANNELS-1:0] pd_reg;
    logic [CHANNELS-1:0] pd_next;
    logic done_reg;
    logic done_next;

    always_comb begin
        pd_next = (pd_reg | down_sel) & ~update_sel;
        done_next = execute;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pd_reg <= POWER_DOWN_RESET;
            done_reg <= 1'b0;
        end else begin
            pd_reg <= pd_next;
            done_reg <= done_next;
        end
    end

    logic bias_reg;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bias_reg <= 1'b1;
        end else begin
            bias_reg <= ~(&pd_next);
        end
    end

    // ------------------------------------------------------------
    // Power-up delay
    // ------------------------------------------------------------
    // delay choice
    logic wake_load;
    logic [DELAY_BITS-1:0] wake_count;
    assign wake_load = |(update_sel & pd_reg);

    always_comb begin
        if (&pd_reg) begin
            wake_count = supply_3v_reg ? DELAY_BITS'(PWRUP_FULL_3V) : DELAY_BITS'(PWRUP_FULL_5V);
        end else begin
            wake_count = DELAY_BITS'(PWRUP_PARTIAL);
        end
    end

    dac_delay_timer u_wake_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .load_i(wake_load),
        .count_i(wake_count),
        .busy_o(settling_hold_o)
    );

    assign power_down_o = pd_reg;
    assign bias_enable_o = bias_reg;
    assign command_done_o = done_reg;
endmodule : dac_serial_command

/* test/dac_serial_command_sva.sv */
// Checker for the octal DAC serial command top module.
// Assumes binding to dac_serial_command; sees only its ports.
`timescale 1ns/1ps
module dac_serial_command_sva
    import dac_cmd_pkg::*;
#(
    parameter int PWRUP_FULL_3V = PWRUP_FULL_3V_CYC
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic serial_clk_i,
    input wire logic select_load_n_i,
    input wire logic serial_in_i,
    input wire logic async_clear_n_i,
    input wire logic supply_3v_i,
    input wire logic chain_out_o,
    input wire logic [CHANNELS*CODE_BITS-1:0] channel_output_o,
    input wire logic [CHANNELS*CODE_BITS-1:0] input_code_o,
    input wire logic [CHANNELS-1:0] power_down_o,
    input wire logic bias_enable_o,
    input wire logic settling_hold_o,
    input wire logic command_done_o
);
    localparam int HOLD_MAX = PWRUP_FULL_3V + 4;
    // ----------------------------------------
    // Hold length, restarted by each command
    // ----------------------------------------
    logic [DELAY_BITS-1:0] hold_cnt;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_cnt <= '0;
        end else if (command_done_o || !settling_hold_o) begin
            hold_cnt <= '0;
        end else begin
            hold_cnt <= hold_cnt + 1'b1;
        end
    end
    // ----------------------------------------
    // Link rises since reset, saturating
    // ----------------------------------------
    logic [5:0] rise_cnt;
    always_ff @(posedge serial_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rise_cnt <= 6'h00;
        end else if (rise_cnt != 6'h20) begin
            rise_cnt <= rise_cnt + 6'h01;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_chain_delay: assert property (@(posedge serial_clk_i) disable iff (!rst_n_i)
        rise_cnt == 6'h20 |-> chain_out_o == $past(serial_in_i, 32)) else $error("chain output delay wrong");
    a_clear_zeroes: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !async_clear_n_i |-> channel_output_o == '0 && input_code_o == '0) else $error("clear not zeroing");
    a_bias_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (&power_down_o) [*2] |-> !bias_enable_o) else $error("bias on with all down");
    a_bias_on: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !(&power_down_o) [*2] |-> bias_enable_o) else $error("bias off with a channel up");
    a_done_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        command_done_o |=> !command_done_o) else $error("done longer than one cycle");
    a_exec_bound: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(select_load_n_i) |-> ##[2:9] command_done_o) else $error("no execution after select rise");
    a_output_cause: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        async_clear_n_i && $past(async_clear_n_i) && $changed(channel_output_o) |-> command_done_o)
        else $error("output code changed without command");
    a_state_cause: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        async_clear_n_i && $past(async_clear_n_i) && $changed({input_code_o, power_down_o}) |-> command_done_o)
        else $error("input or power state changed without command");
    a_hold_cause: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(settling_hold_o) |-> command_done_o) else $error("hold rose without command");
    a_hold_bound: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        settling_hold_o |-> (hold_cnt <= HOLD_MAX)) else $error("hold too long");
endmodule : dac_serial_command_sva

bind dac_serial_command dac_serial_command_sva #(.PWRUP_FULL_3V(PWRUP_FULL_3V)) sva_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .serial_clk_i(serial_clk_i), .select_load_n_i(select_load_n_i),
    .serial_in_i(serial_in_i), .async_clear_n_i(async_clear_n_i), .supply_3v_i(supply_3v_i),
    .chain_out_o(chain_out_o), .channel_output_o(channel_output_o), .input_code_o(input_code_o),
    .power_down_o(power_down_o), .bias_enable_o(bias_enable_o), .settling_hold_o(settling_hold_o),
    .command_done_o(command_done_o)
);

/* test/serial_host_model.sv */
// Host serial master model on the three-wire link.
// Assumes the bench calls send_frame; link clock stands still between frames.
`timescale 1ns/1ps
module serial_host_model (
    output logic serial_clk_o,
    output logic select_load_n_o,
    output logic serial_in_o
);
    initial begin
        serial_clk_o = 1'b0;
        select_load_n_o = 1'b1;
        serial_in_o = 1'b0;
    end
    task automatic send_frame(input logic [31:0] word, input int nbits);
        select_load_n_o = 1'b0;
        #7.3;
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_in_o = word[i];
            #15.0;
            serial_clk_o = 1'b1;
            #15.0;
            serial_clk_o = 1'b0;
        end
        #8.0;
        select_load_n_o = 1'b1;
        serial_in_o = ~serial_in_o;
        #40.0;
    endtask : send_frame
endmodule : serial_host_model

/* test/testbench.sv */
// Self-checking bench for the octal DAC serial command logic.
// Assumes the host model drives the link; expectations queue until done pulses.
`timescale 1ns/1ps
module testbench;
    import dac_cmd_pkg::*;
    typedef struct packed {
        logic [CHANNELS*CODE_BITS-1:0] in_v;
        logic [CHANNELS*CODE_BITS-1:0] dac_v;
        logic [CHANNELS-1:0] pd;
        logic bias;
        logic hold;
    } exp_t;
    logic clock_i, rst_n_i, serial_clk, select_load_n, serial_in, async_clear_n, supply_3v;
    logic chain_out, bias_enable, settling_hold, command_done;
    logic [CHANNELS*CODE_BITS-1:0] channel_output, input_code;
    logic [CHANNELS-1:0] power_down;
    exp_t model;
    exp_t exp_q[$];
    int num_errors, n_compared;
    serial_host_model serial_host_model_i (.serial_clk_o(serial_clk), .select_load_n_o(select_load_n),
        .serial_in_o(serial_in));
    dac_serial_command #(.PWRUP_PARTIAL(4), .PWRUP_FULL_5V(8), .PWRUP_FULL_3V(12)) dac_serial_command_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .serial_clk_i(serial_clk), .select_load_n_i(select_load_n),
        .serial_in_i(serial_in), .async_clear_n_i(async_clear_n), .supply_3v_i(supply_3v),
        .chain_out_o(chain_out), .channel_output_o(channel_output), .input_code_o(input_code),
        .power_down_o(power_down), .bias_enable_o(bias_enable), .settling_hold_o(settling_hold),
        .command_done_o(command_done));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // ----------------------------------------
    // Reference model and checks
    // ----------------------------------------
    task automatic apply(input logic [3:0] cmd, input logic [3:0] addr, input logic [15:0] data);
        logic hit;
        logic wake;
        wake = 1'b0;
        for (int ch = 0; ch < CHANNELS; ch++) begin
            hit = (addr == 4'(ch)) || (addr == ADDR_ALL);
            if (hit && (cmd == CMD_WRITE || cmd == CMD_WRITE_UPDATE_ALL || cmd == CMD_WRITE_UPDATE)) begin
                model.in_v[ch*CODE_BITS +: CODE_BITS] = data;
            end
            if ((hit && (cmd == CMD_UPDATE || cmd == CMD_WRITE_UPDATE)) || cmd == CMD_WRITE_UPDATE_ALL) begin
                // waking a channel starts the hold
                wake = wake | model.pd[ch];
                model.dac_v[ch*CODE_BITS +: CODE_BITS] = model.in_v[ch*CODE_BITS +: CODE_BITS];
                model.pd[ch] = 1'b0;
            end
            if (hit && cmd == CMD_POWER_DOWN) begin
                model.pd[ch] = 1'b1;
            end
        end
        model.bias = ~&model.pd;
        model.hold = wake;
    endtask : apply
    task automatic compare_state(input exp_t e);
        n_compared++;
        if ({input_code, channel_output, power_down, bias_enable, settling_hold} !== e) begin
            $display("mismatch at %0t: channel state differs", $time);
            num_errors++;
        end
    endtask : compare_state
    always @(negedge clock_i) begin
        if (command_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                $display("mismatch at %0t: unexpected completion", $time);
                num_errors++;
            end else begin
                compare_state(exp_q.pop_front());
            end
        end
    end
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic wait_idle();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 40) begin
            @(negedge clock_i);
            n++;
        end
        if (exp_q.size() != 0) begin
            $display("mismatch at %0t: no completion seen", $time);
            num_errors++;
            end_of_test();
        end
    endtask : wait_idle
    task automatic frame(input logic [3:0] cmd, input logic [3:0] addr, input logic [15:0] data, input bit long);
        logic [7:0] lead;
        lead = 8'($urandom);
        apply(cmd, addr, data);
        exp_q.push_back(model);
        serial_host_model_i.send_frame({lead, cmd, addr, data}, long ? 32 : 24);
        wait_idle();
    endtask : frame
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n_i = 1'b0;
        async_clear_n = 1'b1;
        supply_3v = 1'b0;
        model = '0;
        model.bias = 1'b1;
        num_errors = 0;
        n_compared = 0;
        void'($urandom(32'hE8B91A2E));
        repeat (16) @(posedge clock_i);
        @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clock_i);
        compare_state(model);
        for (int ch = 0; ch < CHANNELS; ch++) begin
            frame(CMD_WRITE, 4'(ch), 16'($urandom), ch[0]);
        end
        $display("test writes done");
        frame(CMD_UPDATE, ADDR_ALL, 16'($urandom), 1'b0);
        frame(CMD_WRITE_UPDATE, 4'($urandom % 8), 16'($urandom), 1'b1);
        frame(CMD_WRITE_UPDATE_ALL, 4'h5, 16'hFFFF, 1'b0);
        $display("test updates done");
        frame(CMD_POWER_DOWN, 4'h2, 16'($urandom), 1'b1);
        frame(CMD_UPDATE, 4'h2, 16'($urandom), 1'b0);
        frame(CMD_POWER_DOWN, ADDR_ALL, 16'($urandom), 1'b0);
        @(negedge clock_i);
        supply_3v = 1'b1;
        frame(CMD_UPDATE, 4'h3, 16'($urandom), 1'b1);
        frame(CMD_WRITE_UPDATE, 4'h6, 16'($urandom), 1'b0);
        $display("test power-down done");
        frame(CMD_NOP, ADDR_ALL, 16'($urandom), 1'b1);
        frame(CMD_NOP, 4'h1, 16'($urandom), 1'b0);
        frame(CMD_WRITE, 4'h7, 16'($urandom), 1'b1);
        $display("test no-op and last channel done");
        @(negedge clock_i);
        async_clear_n = 1'b0;
        model.in_v = '0;
        model.dac_v = '0;
        repeat (3) @(negedge clock_i);
        compare_state(model);
        async_clear_n = 1'b1;
        frame(CMD_NOP, 4'h0, 16'($urandom), 1'b0);
        $display("test clear done");
        end_of_test();
    end
endmodule : testbench
